// File: design/ulms_defines.vh
`ifndef ULMS_DEFINES_VH
`define ULMS_DEFINES_VH

// register byte offsets on the bus
`define ULMS_OFS_RX_DATA    8'h00
`define ULMS_OFS_LINE_STAT  8'h04
`define ULMS_OFS_MODEM_STAT 8'h08
`define ULMS_OFS_MODEM_CTRL 8'h0c
`define ULMS_OFS_INT_STAT   8'h10
`define ULMS_OFS_INT_CLEAR  8'h14
`define ULMS_OFS_INT_ENABLE 8'h18
`define ULMS_OFS_RX_SHIFT   8'h1c

// line status fields
`define ULMS_LS_READY       0
`define ULMS_LS_OVERRUN     1

// modem status fields
`define ULMS_MS_D_CTS       0
`define ULMS_MS_D_DSR       1
`define ULMS_MS_TE_CALL     2
`define ULMS_MS_D_CAR       3

// modem control fields
`define ULMS_MC_DTR         0
`define ULMS_MC_RTS         1
`define ULMS_MC_OUT1        2
`define ULMS_MC_OUT2        3
`define ULMS_MC_LOOP        4
`define ULMS_MC_WIDTH       5

// interrupt status / clear / enable fields
`define ULMS_INT_MODEM      0
`define ULMS_INT_OVERRUN    1
`define ULMS_INT_RX         2
`define ULMS_INT_WIDTH      3

// reset values
`define ULMS_MC_RESET       5'h00
`define ULMS_IE_RESET       3'h0
`define ULMS_SYNC_RESET     4'hf

`endif

// File: design/ulms_sync.v
`timescale 1ns/1ps
// two-flop synchroniser, one chain per bit
module ulms_sync #(
  parameter       WIDTH = 4,
  parameter [3:0] INIT  = 4'hf
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // async in, synced out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_q;
      reg stable_q;
      // first stage feeds only the second stage
      always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q   <= INIT[i];
          stable_q <= INIT[i];
        end else begin
          meta_q   <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule // ulms_sync

// File: design/ulms_rx_status.v
`timescale 1ns/1ps
// receive holding fifo with overrun and data ready status
module ulms_rx_status #(
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       rst_n,
  // completed characters from the receive shifter
  input  wire       rx_char_valid,
  input  wire [7:0] rx_char,
  // host side
  input  wire       pop,
  input  wire       clr_overrun,
  output wire [7:0] head_data,
  output wire [7:0] shift_data,
  output wire       data_ready,
  output wire       overrun,
  output wire       overrun_evt,
  output wire       push_evt
);

  reg  [7:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wr_q;
  reg  [AW-1:0] rd_q;
  reg  [AW:0]   cnt_q;
  reg  [7:0]  shift_q;
  reg         ovr_q;
  wire        full;
  wire        empty;
  wire        do_pop;
  wire        do_push;

  assign full    = (cnt_q == DEPTH[AW:0]);
  assign empty   = (cnt_q == {(AW+1){1'b0}});
  assign do_pop  = pop && !empty;
  // a pop in the same cycle frees a slot, so that char is not lost
  assign do_push = rx_char_valid && (!full || do_pop);
  assign overrun_evt = rx_char_valid && full && !do_pop; // [RULE_01]
  assign push_evt    = do_push;

  // storage; on overrun the array is left alone
  always @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_q] <= rx_char; // [RULE_02]
    end
  end

  // pointers, count, shift copy and sticky overrun
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q    <= {AW{1'b0}};
      rd_q    <= {AW{1'b0}};
      cnt_q   <= {(AW+1){1'b0}};
      shift_q <= 8'h00;
      ovr_q   <= 1'b0;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
      if (rx_char_valid) begin
        shift_q <= rx_char; // overrun overwrites the shifter copy [RULE_02]
      end
      // set wins over a clearing read in the same cycle
      if (overrun_evt) begin
        ovr_q <= 1'b1; // [RULE_01]
      end else if (clr_overrun) begin
        ovr_q <= 1'b0;
      end
    end
  end

  assign head_data  = empty ? 8'h00 : mem[rd_q];
  assign shift_data = shift_q;
  assign data_ready = !empty; // [RULE_03]
  assign overrun    = ovr_q;

endmodule // ulms_rx_status

// File: design/ulms_top.v
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "ulms_defines.vh"
// How it works
// [RULE_01] overrun flag sets when full fifo receives more
// [RULE_02] overrun char stays in shifter, fifo untouched
// [RULE_03] data ready high while fifo holds data
// [RULE_04] four change bits set on input changes
// [RULE_05] reading modem status clears change bits
// [RULE_06] bit 7: inverted carrier, loopback user output two
// [RULE_07] bit 6: inverted call alert, loopback output one
// [RULE_08] bit 5: inverted dsr, loopback dtr bit
// [RULE_09] bit 4: inverted cts, loopback rts bit
// [RULE_10] bit 3 flags carrier change, raises interrupt
// [RULE_11] bit 2 flags call alert rising, raises interrupt
// [RULE_12] any change bit set raises modem interrupt
// [RULE_13] bit 0 flags cts change, raises interrupt
// [RULE_14] bit 1 flags dsr change, read clears
// [RULE_15] modem inputs synchronised before change detection
module ulms_top #(
  parameter RX_DEPTH = 16,
  parameter RX_AW    = 4
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // receive shifter
  input  wire        rx_char_valid,
  input  wire [7:0]  rx_char,
  // modem control inputs, active low
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        call_alert_in_n,
  input  wire        carrier_detect_n,
  // modem control outputs, active low
  output reg         dtr_n,
  output reg         rts_n,
  output reg         user_output_one_n,
  output reg         user_output_two_n,
  // interrupts
  output reg         irq,
  output reg         modem_irq
);

  // bus phase capture
  reg  [7:0]  addr_q;
  reg         wr_pend_q;
  // modem control and change state
  reg  [`ULMS_MC_WIDTH-1:0]  modem_control_reg_q;
  reg  [3:0]                 delta_q;
  reg  [3:0]                 delta_d;
  reg  [3:0]                 prev_q;
  // interrupt registers
  reg  [`ULMS_INT_WIDTH-1:0] int_stat_q;
  reg  [`ULMS_INT_WIDTH-1:0] int_stat_d;
  reg  [`ULMS_INT_WIDTH-1:0] int_en_q;
  // read mux output
  reg  [31:0] rdata_d;

  // bus decode
  wire        addr_phase;
  wire        rd_take;
  wire        rd_rx;
  wire        rd_ls;
  wire        rd_ms;
  wire        wr_mc;
  wire        wr_ic;
  wire        wr_ie;
  // modem path
  wire        loop;
  wire [3:0]  loop_lvl;
  wire [3:0]  pin_sync;
  wire [3:0]  raw;
  wire [3:0]  change;
  wire [7:0]  modem_status_reg;
  wire [7:0]  line_status_reg;
  // receive side
  wire [7:0]  head_data;
  wire [7:0]  shift_data;
  wire        data_ready;
  wire        overrun;
  wire        overrun_evt;
  wire        push_evt;

  // a transfer is taken when selected, non-idle and the bus is ready
  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_take    = addr_phase && !hwrite;
  assign rd_rx      = rd_take && (haddr == `ULMS_OFS_RX_DATA);
  assign rd_ls      = rd_take && (haddr == `ULMS_OFS_LINE_STAT);
  assign rd_ms      = rd_take && (haddr == `ULMS_OFS_MODEM_STAT);
  assign wr_mc      = wr_pend_q && (addr_q == `ULMS_OFS_MODEM_CTRL);
  assign wr_ic      = wr_pend_q && (addr_q == `ULMS_OFS_INT_CLEAR);
  assign wr_ie      = wr_pend_q && (addr_q == `ULMS_OFS_INT_ENABLE);

  // handshake: zero wait states, every transfer OKAY
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // address phase capture; writes land at the end of the data phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q    <= 8'h00;
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_q <= haddr;
      end
    end
  end

  // read data registered at the address edge, stands in data phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata <= rdata_d;
    end
  end

  // sync the modem pins before looking for edges
  ulms_sync #(
    .WIDTH (4),
    .INIT  (`ULMS_SYNC_RESET)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in ({carrier_detect_n, call_alert_in_n, dsr_n, cts_n}),
    .sync_out (pin_sync)
  ); // [RULE_15]

  // receive fifo and line status
  ulms_rx_status #(
    .DEPTH (RX_DEPTH),
    .AW    (RX_AW)
  ) u_rx (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .rx_char_valid (rx_char_valid),
    .rx_char       (rx_char),
    .pop           (rd_rx),
    .clr_overrun   (rd_ls),
    .head_data     (head_data),
    .shift_data    (shift_data),
    .data_ready    (data_ready),
    .overrun       (overrun),
    .overrun_evt   (overrun_evt),
    .push_evt      (push_evt)
  );

  // active-low view of the four inputs; loopback takes control bits
  assign loop = modem_control_reg_q[`ULMS_MC_LOOP];
  // loopback crosses dtr to dsr and rts to cts, not bit for bit
  assign loop_lvl[0] = ~modem_control_reg_q[`ULMS_MC_RTS]; // [RULE_09]
  assign loop_lvl[1] = ~modem_control_reg_q[`ULMS_MC_DTR]; // [RULE_08]
  assign loop_lvl[2] = ~modem_control_reg_q[`ULMS_MC_OUT1]; // [RULE_07]
  assign loop_lvl[3] = ~modem_control_reg_q[`ULMS_MC_OUT2]; // [RULE_06]
  assign raw  = loop ? loop_lvl : pin_sync;

  // per-input change detect: cts, dsr, call alert, carrier
  assign change[`ULMS_MS_D_CTS]   = raw[0] ^ prev_q[0]; // [RULE_13]
  assign change[`ULMS_MS_D_DSR]   = raw[1] ^ prev_q[1]; // [RULE_14]
  assign change[`ULMS_MS_TE_CALL] = raw[2] && !prev_q[2]; // [RULE_11]
  assign change[`ULMS_MS_D_CAR]   = raw[3] ^ prev_q[3]; // [RULE_10]

  // status bits are the complement of the active-low inputs
  assign modem_status_reg[7] = ~raw[3]; // [RULE_06]
  assign modem_status_reg[6] = ~raw[2]; // [RULE_07]
  assign modem_status_reg[5] = ~raw[1]; // [RULE_08]
  assign modem_status_reg[4] = ~raw[0]; // [RULE_09]
  assign modem_status_reg[3:0] = delta_q;

  assign line_status_reg = {6'h00, overrun, data_ready};

  // change bits: a new change beats a clearing read in the same cycle
  always @* begin
    delta_d = rd_ms ? 4'h0 : delta_q; // [RULE_05]
    delta_d = delta_d | change; // [RULE_04]
  end

  // sticky interrupt sources; set wins over a clear write
  always @* begin
    int_stat_d = int_stat_q;
    if (wr_ic) begin
      int_stat_d = int_stat_d & ~hwdata[`ULMS_INT_WIDTH-1:0];
    end
    int_stat_d[`ULMS_INT_MODEM]   = int_stat_d[`ULMS_INT_MODEM] | (|change); // [RULE_12]
    int_stat_d[`ULMS_INT_OVERRUN] = int_stat_d[`ULMS_INT_OVERRUN] | overrun_evt;
    int_stat_d[`ULMS_INT_RX]      = int_stat_d[`ULMS_INT_RX] | push_evt;
  end

  // read mux; values seen before this edge's side effects
  always @* begin
    rdata_d = 32'h0000_0000;
    case (haddr)
      `ULMS_OFS_RX_DATA:    rdata_d = {24'h000000, head_data};
      `ULMS_OFS_LINE_STAT:  rdata_d = {24'h000000, line_status_reg};
      `ULMS_OFS_MODEM_STAT: rdata_d = {24'h000000, modem_status_reg};
      `ULMS_OFS_MODEM_CTRL: rdata_d = {27'h0000000, modem_control_reg_q};
      `ULMS_OFS_INT_STAT:   rdata_d = {29'h00000000, int_stat_q};
      `ULMS_OFS_INT_ENABLE: rdata_d = {29'h00000000, int_en_q};
      `ULMS_OFS_RX_SHIFT:   rdata_d = {24'h000000, shift_data};
      default:              rdata_d = 32'h0000_0000;
    endcase
  end

  // modem control register; holds loopback and the four outputs
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modem_control_reg_q <= `ULMS_MC_RESET;
    end else if (wr_mc) begin
      modem_control_reg_q <= hwdata[`ULMS_MC_WIDTH-1:0];
    end
  end

  // interrupt enable register
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_en_q <= `ULMS_IE_RESET;
    end else if (wr_ie) begin
      int_en_q <= hwdata[`ULMS_INT_WIDTH-1:0];
    end
  end

  // previous input levels and latched change bits
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q  <= `ULMS_SYNC_RESET;
      delta_q <= 4'h0;
    end else begin
      prev_q  <= raw;
      delta_q <= delta_d; // [RULE_04]
    end
  end

  // sticky interrupt sources
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_stat_q <= `ULMS_IE_RESET;
    end else begin
      int_stat_q <= int_stat_d;
    end
  end

  // level interrupts from next-state values, saving a cycle of lag
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq       <= 1'b0;
      modem_irq <= 1'b0;
    end else begin
      irq       <= |(int_stat_d & int_en_q);
      modem_irq <= |delta_d; // [RULE_12]
    end
  end

  // loopback parks the pins inactive so the modem sees nothing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_n             <= 1'b1;
      rts_n             <= 1'b1;
      user_output_one_n <= 1'b1;
      user_output_two_n <= 1'b1;
    end else begin
      dtr_n             <= loop | ~modem_control_reg_q[`ULMS_MC_DTR];
      rts_n             <= loop | ~modem_control_reg_q[`ULMS_MC_RTS];
      user_output_one_n <= loop | ~modem_control_reg_q[`ULMS_MC_OUT1];
      user_output_two_n <= loop | ~modem_control_reg_q[`ULMS_MC_OUT2];
    end
  end

endmodule // ulms_top

// File: verif/ulms_modem_model.sv
`timescale 1ns/1ps
// far-side modem: drives its four active-low control lines from a level word
module ulms_modem_model (
  // wanted levels: cts, dsr, call alert, carrier
  input  wire [3:0] level,
  // active-low control lines
  output wire       cts_n,
  output wire       dsr_n,
  output wire       call_alert_in_n,
  output wire       carrier_detect_n
);
  // lines are always driven, so a released state never occurs
  assign {carrier_detect_n, call_alert_in_n, dsr_n, cts_n} = level;
endmodule // ulms_modem_model

// File: verif/ulms_checker.sv
`timescale 1ns/1ps
// watches bus reads and modem pins of the status block
module ulms_checker (
  // clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  // bus
  input wire        hsel,
  input wire [7:0]  haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  // modem side
  input wire        cts_n,
  input wire        dsr_n,
  input wire        call_alert_in_n,
  input wire        carrier_detect_n,
  input wire        modem_irq
);
  reg        wa_q;
  reg        wm_q;
  reg  [4:0] mc_q;
  reg  [3:0] pin_q;
  reg  [3:0] quiet_q;
  wire [3:0] pin   = {carrier_detect_n, call_alert_in_n, dsr_n, cts_n};
  wire       take  = hsel & htrans[1] & hready;
  wire       rd_ms = take & !hwrite & (haddr == 8'h08);
  wire       calm  = (quiet_q > 4'h5);
  wire       lp    = mc_q[4];
  // shadow control reg; counter restarts on writes and pin moves so sync lag settles
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wa_q    <= 1'b0;
      wm_q    <= 1'b0;
      mc_q    <= 5'h00;
      pin_q   <= 4'hf;
      quiet_q <= 4'h0;
    end else begin
      wa_q    <= take & hwrite;
      wm_q    <= take & hwrite & (haddr == 8'h0c);
      mc_q    <= wm_q ? hwdata[4:0] : mc_q;
      pin_q   <= pin;
      quiet_q <= (wa_q | (pin != pin_q)) ? 4'h0 : quiet_q + {3'h0, ~&quiet_q};
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence irq_soon; ##[1:4] modem_irq; endsequence
  sequence irq_off; ##2 !modem_irq; endsequence
  carrier_delta_a: assert property (!lp && $changed(carrier_detect_n) |-> irq_soon)
    else $error("carrier change gave no modem interrupt");
  call_rise_a: assert property (!lp && $rose(call_alert_in_n) |-> irq_soon)
    else $error("call alert rise gave no modem interrupt");
  call_fall_a: assert property (!lp && calm && !modem_irq && $fell(call_alert_in_n)
    |-> ##1 !modem_irq [*4])
    else $error("call alert fall raised modem interrupt");
  cts_delta_a: assert property (!lp && $changed(cts_n) |-> irq_soon)
    else $error("cts change gave no modem interrupt");
  dsr_delta_a: assert property (!lp && $changed(dsr_n) |-> irq_soon)
    else $error("dsr change gave no modem interrupt");
  read_clear_a: assert property (rd_ms && calm |-> irq_off)
    else $error("modem status read left interrupt up");
  norm_mirror_a: assert property (rd_ms && calm && !lp |-> ##1 hrdata[7:4] == ~pin)
    else $error("modem status levels do not mirror pins");
  loop_mirror_a: assert property (rd_ms && calm && lp
    |-> ##1 hrdata[7:4] == {mc_q[3], mc_q[2], mc_q[0], mc_q[1]})
    else $error("loopback levels do not mirror control");
endmodule // ulms_checker

bind ulms_top ulms_checker chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .cts_n(cts_n), .dsr_n(dsr_n), .call_alert_in_n(call_alert_in_n),
  .carrier_detect_n(carrier_detect_n), .modem_irq(modem_irq));

// File: verif/uart_line_modem_status_test.sv
`timescale 1ns/1ps
// self-checking bench for the line and modem status block
module uart_line_modem_status_test;
  reg         ref_clk, rst_n, hsel, hwrite, rx_char_valid;
  reg  [7:0]  haddr, rx_char;
  reg  [1:0]  htrans;
  reg  [31:0] hwdata, rd;
  reg  [3:0]  lvl, nx;
  integer     errors, check_count, i;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, cts_n, dsr_n, ca_n, car_n;
  wire        dtr_n, rts_n, o1_n, o2_n, irq, modem_irq;
  ulms_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .cts_n(cts_n), .dsr_n(dsr_n), .call_alert_in_n(ca_n),
    .carrier_detect_n(car_n), .dtr_n(dtr_n), .rts_n(rts_n), .user_output_one_n(o1_n),
    .user_output_two_n(o2_n), .irq(irq), .modem_irq(modem_irq));
  ulms_modem_model modem_u (.level(lvl), .cts_n(cts_n), .dsr_n(dsr_n),
    .call_alert_in_n(ca_n), .carrier_detect_n(car_n));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task close_out;
    if (errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task check(input [31:0] seen, input [31:0] exp, input string what);
    check_count = check_count + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // hready is sampled at the rising edge, before that edge's updates land
  task wait_rdy;
    integer t;
    t = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      t = t + 1;
      if (t > 20) begin
        errors = errors + 1;
        close_out;
      end
      @(posedge ref_clk);
    end
  endtask
  // one single word transfer; read data taken at the data phase edge
  task bus(input w, input [7:0] a, input [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    wait_rdy;
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy;
    rd = hrdata;
  endtask
  task rchk(input [7:0] a, input [31:0] e, input string w);
    bus(1'b0, a, 32'h0);
    check(rd, e, w);
  endtask
  task look(input integer k);
    repeat (k) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task push(input [7:0] c);
    rx_char_valid <= 1'b1; rx_char <= c;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    @(posedge ref_clk);
  endtask
  task t_regs;
    rchk(8'h0c, 32'h0, "modem_control");
    rchk(8'h18, 32'h0, "int_enable");
    rchk(8'h20, 32'h0, "unmapped");
    check(hresp, 32'h0, "hresp");
    check(hreadyout, 32'h1, "hreadyout");
  endtask
  // each pin falls then rises; call alert flags only its rise
  task t_modem;
    for (i = 0; i < 8; i = i + 1) begin
      nx = lvl ^ (4'h1 << i[1:0]);
      lvl <= nx;
      repeat (6) @(posedge ref_clk);
      rchk(8'h08, {24'h0, ~nx, (i == 2) ? 4'h0 : 4'h1 << i[1:0]}, "modem_status");
      rchk(8'h08, {24'h0, ~nx, 4'h0}, "modem_status_again");
    end
  endtask
  task t_irq;
    bus(1'b1, 8'h18, 32'h1);
    lvl <= 4'he;
    look(6);
    check(irq, 32'h1, "irq");
    check(modem_irq, 32'h1, "modem_irq");
    @(posedge ref_clk);
    bus(1'b1, 8'h18, 32'h0);
    look(2);
    check(irq, 32'h0, "irq_masked");
    @(posedge ref_clk);
    bus(1'b1, 8'h18, 32'h1);
    rchk(8'h08, 32'h11, "modem_status_irq");
    look(2);
    check(modem_irq, 32'h0, "modem_irq_read");
    check(irq, 32'h1, "irq_sticky");
    @(posedge ref_clk);
    rchk(8'h10, 32'h1, "int_status");
    bus(1'b1, 8'h14, 32'h1);
    look(2);
    check(irq, 32'h0, "irq_cleared");
    @(posedge ref_clk);
    rchk(8'h10, 32'h0, "int_status_cleared");
    lvl <= 4'hf;
    repeat (6) @(posedge ref_clk);
    rchk(8'h08, 32'h01, "modem_status_back");
  endtask
  task t_loop;
    bus(1'b1, 8'h0c, 32'h0f);
    look(2);
    check({dtr_n, rts_n, o1_n, o2_n}, 32'h0, "pins_on");
    @(posedge ref_clk);
    bus(1'b1, 8'h0c, 32'h15);
    repeat (6) @(posedge ref_clk);
    rchk(8'h08, 32'h62, "loop_status");
    check({dtr_n, rts_n, o1_n, o2_n}, 32'hf, "pins_loop");
    bus(1'b1, 8'h0c, 32'h1a);
    repeat (6) @(posedge ref_clk);
    rchk(8'h08, 32'h9f, "loop_status_two");
    bus(1'b1, 8'h0c, 32'h0);
    repeat (6) @(posedge ref_clk);
    rchk(8'h08, 32'h09, "loop_exit");
  endtask
  // mid-run reset in the cycle the write driving the outputs lands, then the first transfer after release
  task t_reset;
    bus(1'b1, 8'h0c, 32'h0f);
    rst_n <= 1'b0;
    look(1);
    check(hrdata, 32'h0, "reset_hrdata");
    check({hreadyout, irq, modem_irq}, 32'h0, "reset_outputs");
    check({dtr_n, rts_n, o1_n, o2_n}, 32'hf, "reset_pins");
    @(posedge ref_clk);
    rst_n <= 1'b1;
    look(1);
    check(hreadyout, 32'h1, "ready_after_reset");
    @(posedge ref_clk);
    rchk(8'h0c, 32'h0, "modem_control_reset");
  endtask
  // fill to sixteen, overrun with one more, then drain in order
  task t_rx;
    for (i = 0; i < 16; i = i + 1) push(i[7:0]);
    rchk(8'h04, 32'h1, "ready_full");
    push(8'hee);
    rchk(8'h04, 32'h3, "overrun");
    rchk(8'h10, 32'h6, "int_status_rx");
    rchk(8'h04, 32'h1, "overrun_read");
    rchk(8'h1c, 32'hee, "shift_copy");
    for (i = 0; i < 16; i = i + 1) rchk(8'h00, i, "fifo_data");
    rchk(8'h04, 32'h0, "ready_empty");
  endtask
  initial begin
    errors = 0; check_count = 0; rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0;
    haddr = 8'h0; htrans = 2'h0; hwdata = 32'h0; rx_char_valid = 1'b0;
    rx_char = 8'h0; lvl = 4'hf;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs;
    t_modem;
    t_irq;
    t_loop;
    t_reset;
    t_rx;
    close_out;
  end
endmodule // uart_line_modem_status_test
